// ===== hdl/rx_bitcheck_pkg.sv
/*
  Constants, register map, field layout and state encoding for the
  receive bit-check and receive buffer block.
  Assumes an 8-bit register port with 5-bit addresses and one clock.
*/
package rx_bitcheck_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;

  localparam logic [4:0] ADDR_CTRL1 = 5'h01;
  localparam logic [4:0] ADDR_CTRL3 = 5'h03;
  localparam logic [4:0] ADDR_CTRL4 = 5'h04;
  localparam logic [4:0] ADDR_CTRL5 = 5'h05;
  localparam logic [4:0] ADDR_CTRL6 = 5'h06;
  localparam logic [4:0] ADDR_CTRL7 = 5'h07;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_BUFFER = 5'h11;

  localparam int OPM_LSB = 0;
  localparam int TS_BIT = 3;
  localparam int PS_BIT = 4;
  localparam int IRQ_LSB = 5;
  localparam int CLKON_BIT = 0;
  localparam int LIMIT_LSB = 0;
  localparam int NBC_LSB = 6;

  localparam logic [2:0] OPM_RX_POLL = 3'h2;
  localparam logic [2:0] OPM_RX_CONT = 3'h3;

  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [7:0] CTRL4_RESET = 8'h00;
  localparam logic [7:0] CTRL5_RESET = 8'h4e;
  localparam logic [7:0] CTRL6_RESET = 8'h18;
  localparam logic [7:0] CTRL7_RESET = 8'h00;

  localparam logic [4:0] BITS_PER_STEP = 5'h03;
  localparam logic [4:0] EDGES_PER_BIT = 5'h02;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [4:0] IRQ_LEVEL_0 = 5'h01;
  localparam logic [4:0] IRQ_LEVEL_1 = 5'h04;
  localparam logic [4:0] IRQ_LEVEL_2 = 5'h08;
  localparam logic [4:0] IRQ_LEVEL_3 = 5'h0c;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PLL = 3'b001,
    ST_SIGPROC = 3'b011,
    ST_CHECK = 3'b010,
    ST_RECV = 3'b110,
    ST_SLEEP = 3'b100
  } rx_state_e;
endpackage

// ===== hdl/edge_interval_timer.sv
/*
  Edge detector and edge-to-edge interval counter in check ticks.
  Assumes demod_in and tick are synchronous to clk; tick is one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module edge_interval_timer
  import rx_bitcheck_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic demod_in,
  output logic edge_seen,
  output logic rising,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic prev;
    logic [W-1:0] cnt;
  } timer_s;

  timer_s r_reg;
  timer_s r_next;

  assign edge_seen = enable && (demod_in != r_reg.prev);
  assign rising = demod_in;
  assign count = r_reg.cnt;

  always_comb begin
    r_next = r_reg;
    r_next.prev = demod_in;
    if (!enable) begin
      r_next.cnt = '0;
    end else if (edge_seen) begin
      r_next.cnt = '0;
    end else if (tick && r_reg.cnt != {W{1'b1}}) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  a_edge_restart:
    assert property (@(posedge clk) disable iff (rst) edge_seen |=> count == '0)
    else $error("interval count not restarted at edge");
  a_tick_step:
    assert property (@(posedge clk) disable iff (rst)
      (enable && !edge_seen && !tick) |=> count == $past(count))
    else $error("interval count moved without a tick");
endmodule
`default_nettype wire

// ===== hdl/rx_bitcheck_and_receive_buffer.sv
/*
  Receive start-up sequencing, bit-check, Manchester decoder,
  receive buffer with byte counter and host interrupt.
  Assumes all inputs synchronous to clk; tick is a one-cycle pulse per
  check tick; wake is a one-cycle pulse from the sleep timer; the
  register port reads data one cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_bitcheck_and_receive_buffer
  import rx_bitcheck_pkg::*;
#(
  parameter int BUF_DEPTH = 16,
  parameter int SIGPROC_TICKS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic pll_lock,
  input wire logic tick,
  input wire logic demod_in,
  input wire logic cs_active,
  input wire logic wake,
  input wire logic irq_clear,
  output logic pll_enable,
  output logic sigproc_enable,
  output logic rx_active,
  output logic irq,
  output logic serial_out_transparent,
  output logic serial_out_oe_n
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(BUF_DEPTH);
  localparam logic [7:0] SETTLE_LAST = 8'(SIGPROC_TICKS - 1);

  typedef struct packed {
    rx_state_e st;
    logic [7:0] ctrl1;
    logic [7:0] ctrl3;
    logic [7:0] ctrl4;
    logic [7:0] ctrl5;
    logic [7:0] ctrl6;
    logic [7:0] ctrl7;
    logic [4:0] checks;
    logic armed;
    logic [7:0] settle;
    logic synced;
    logic at_mid;
    logic [7:0] shift;
    logic [2:0] nbits;
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
    logic irq;
    logic [7:0] rdata;
    logic sot;
    logic sot_oe_n;
  } rx_s;

  rx_s r_reg;
  rx_s r_next;

  logic edge_seen;
  logic rising;
  logic [CNT_W-1:0] cnt;
  logic timer_en;
  logic enter_recv;
  logic bit_err;

  function automatic logic is_rx(input logic [7:0] c1);
    is_rx = (c1[OPM_LSB +: 3] == OPM_RX_POLL) || (c1[OPM_LSB +: 3] == OPM_RX_CONT);
  endfunction

  function automatic logic is_cfg(input logic [4:0] a);
    is_cfg = (a == ADDR_CTRL1) || (a == ADDR_CTRL4) || (a == ADDR_CTRL5) ||
             (a == ADDR_CTRL6) || (a == ADDR_CTRL7);
  endfunction

  function automatic logic [4:0] irq_level(input logic [1:0] sel);
    case (sel)
      2'h0: irq_level = IRQ_LEVEL_0;
      2'h1: irq_level = IRQ_LEVEL_1;
      2'h2: irq_level = IRQ_LEVEL_2;
      default: irq_level = IRQ_LEVEL_3;
    endcase
  endfunction

  // Limits and 2T window
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] lsum;
  logic [7:0] ldiff;
  logic [7:0] lo2;
  logic [7:0] hi2;
  logic [4:0] need;
  logic ts;
  logic ps;

  assign lo = {2'h0, r_reg.ctrl5[LIMIT_LSB +: 6]};
  assign hi = {2'h0, r_reg.ctrl6[LIMIT_LSB +: 6]};
  assign lsum = lo + hi;
  assign ldiff = hi - lo;
  assign lo2 = lsum - (ldiff >> 1);
  assign hi2 = lsum + ((ldiff + 8'h01) >> 1);
  assign need = 5'(r_reg.ctrl5[NBC_LSB +: 2]) * BITS_PER_STEP * EDGES_PER_BIT;
  assign ts = r_reg.ctrl1[TS_BIT];
  assign ps = r_reg.ctrl1[PS_BIT];
  assign timer_en = (r_reg.st == ST_CHECK) || (r_reg.st == ST_RECV);

  edge_interval_timer #(
    .W(CNT_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .enable(timer_en),
    .tick(tick),
    .demod_in(demod_in),
    .edge_seen(edge_seen),
    .rising(rising),
    .count(cnt)
  );

  always_comb begin
    logic push;
    logic pop;
    logic take;
    logic fail;
    logic t_ok;
    logic d_ok;
    logic [7:0] byte_in;
    push = 1'b0;
    pop = 1'b0;
    take = 1'b0;
    fail = 1'b0;
    t_ok = 1'b0;
    d_ok = 1'b0;
    byte_in = '0;
    enter_recv = 1'b0;
    bit_err = 1'b0;
    r_next = r_reg;
    r_next.rdata = '0;
    if (irq_clear) begin
      r_next.irq = 1'b0;
    end
    if (wr) begin
      case (addr)
        ADDR_CTRL1: r_next.ctrl1 = wdata;
        ADDR_CTRL3: r_next.ctrl3 = wdata;
        ADDR_CTRL4: r_next.ctrl4 = wdata;
        ADDR_CTRL5: r_next.ctrl5 = wdata;
        ADDR_CTRL6: r_next.ctrl6 = wdata;
        ADDR_CTRL7: r_next.ctrl7 = wdata;
        default: r_next.ctrl7 = r_reg.ctrl7;
      endcase
    end
    if (rd) begin
      case (addr)
        ADDR_CTRL1: r_next.rdata = r_reg.ctrl1;
        ADDR_CTRL3: r_next.rdata = r_reg.ctrl3;
        ADDR_CTRL4: r_next.rdata = r_reg.ctrl4;
        ADDR_CTRL5: r_next.rdata = r_reg.ctrl5;
        ADDR_CTRL6: r_next.rdata = r_reg.ctrl6;
        ADDR_CTRL7: r_next.rdata = r_reg.ctrl7;
        ADDR_STATUS: r_next.rdata = {r_reg.st, 5'(r_reg.count)};
        ADDR_BUFFER: begin
          r_next.rdata = r_reg.mem[r_reg.rp];
          pop = (r_reg.count != '0);
        end
        default: r_next.rdata = '0;
      endcase
    end

    unique case (r_reg.st)
      ST_IDLE: begin
        if (is_rx(r_reg.ctrl1)) begin
          r_next.st = ST_PLL;
        end
      end
      ST_PLL: begin
        if (pll_lock) begin
          r_next.st = ST_SIGPROC;
          r_next.settle = '0;
        end
      end
      ST_SIGPROC: begin
        if (tick) begin
          r_next.settle = r_reg.settle + 8'h01;
          if (r_reg.settle == SETTLE_LAST) begin
            r_next.st = ST_CHECK;
            r_next.checks = '0;
            r_next.armed = 1'b0;
          end
        end
      end
      ST_CHECK: begin
        if (need == '0) begin
          enter_recv = 1'b1;
        end else if (edge_seen && !r_reg.armed) begin
          r_next.armed = 1'b1;
        end else if (edge_seen) begin
          if (cnt < lo || cnt >= hi) begin
            fail = 1'b1;
          end else if (r_reg.checks + 5'h01 == need) begin
            enter_recv = 1'b1;
          end else begin
            r_next.checks = r_reg.checks + 5'h01;
          end
        end else if (r_reg.armed && cnt >= hi) begin
          fail = 1'b1;
        end
        if (fail) begin
          r_next.checks = '0;
          r_next.armed = 1'b0;
          if (r_reg.ctrl1[OPM_LSB +: 3] == OPM_RX_POLL) begin
            r_next.st = ST_SLEEP;
          end
        end
        if (enter_recv) begin
          r_next.st = ST_RECV;
          r_next.ctrl3[CLKON_BIT] = 1'b1;
          r_next.synced = 1'b0;
          r_next.at_mid = 1'b0;
          r_next.nbits = '0;
          if (!ts && !ps) begin
            r_next.irq = 1'b1;
          end
        end
      end
      ST_RECV: begin
        t_ok = (cnt >= lo) && (cnt < hi);
        d_ok = (cnt >= lo2) && (cnt < hi2);
        if (!ts) begin
          if (edge_seen) begin
            if (!t_ok && !d_ok) begin
              bit_err = 1'b1;
            end else if (!r_reg.synced) begin
              if (d_ok) begin
                r_next.synced = 1'b1;
                r_next.at_mid = 1'b1;
                take = 1'b1;
              end
            end else if (t_ok) begin
              r_next.at_mid = !r_reg.at_mid;
              take = !r_reg.at_mid;
            end else if (r_reg.at_mid) begin
              take = 1'b1;
            end else begin
              bit_err = 1'b1;
            end
          end else if (cnt >= hi2) begin
            bit_err = 1'b1;
          end
        end
        if (take) begin
          byte_in = {r_reg.shift[6:0], rising};
          r_next.shift = byte_in;
          r_next.nbits = r_reg.nbits + 3'h1;
          push = (r_reg.nbits == LAST_BIT);
        end
        if (bit_err) begin
          r_next.irq = 1'b1;
          r_next.st = ST_SIGPROC;
          r_next.settle = '0;
          r_next.nbits = '0;
          r_next.synced = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          r_next.st = ST_PLL;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    if (push) begin
      r_next.mem[r_reg.wp] = byte_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop || (push && r_reg.count == FULL)) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    if (push && !pop && r_reg.count != FULL) begin
      r_next.count = r_reg.count + 1'b1;
      if (5'(r_reg.count) + 5'h01 == irq_level(r_reg.ctrl1[IRQ_LSB +: 2])) begin
        r_next.irq = 1'b1;
      end
    end else if (pop && !push) begin
      r_next.count = r_reg.count - 1'b1;
    end

    if (wr && is_cfg(addr) && r_reg.st == ST_RECV) begin
      r_next.wp = '0;
      r_next.rp = '0;
      r_next.count = '0;
      r_next.nbits = '0;
      r_next.synced = 1'b0;
      r_next.st = ST_SIGPROC;
      r_next.settle = '0;
    end
    if (!is_rx(r_next.ctrl1)) begin
      r_next.st = ST_IDLE;
    end

    r_next.sot_oe_n = !(r_reg.st == ST_RECV && ts && !cs_active);
    r_next.sot = r_next.sot_oe_n ? 1'b0 : demod_in;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.ctrl1 <= CTRL1_RESET;
      r_reg.ctrl3 <= CTRL3_RESET;
      r_reg.ctrl4 <= CTRL4_RESET;
      r_reg.ctrl5 <= CTRL5_RESET;
      r_reg.ctrl6 <= CTRL6_RESET;
      r_reg.ctrl7 <= CTRL7_RESET;
      r_reg.sot_oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;
  assign irq = r_reg.irq;
  assign pll_enable = (r_reg.st != ST_IDLE) && (r_reg.st != ST_SLEEP);
  assign sigproc_enable = pll_enable && (r_reg.st != ST_PLL);
  assign rx_active = timer_en;
  assign serial_out_transparent = r_reg.sot;
  assign serial_out_oe_n = r_reg.sot_oe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pll_before_sig:
    assert property ((r_reg.st == ST_SIGPROC && $past(r_reg.st) == ST_PLL) |-> $past(pll_lock))
    else $error("signal processing started without lock");
  a_check_low_fail:
    assert property ((r_reg.st == ST_CHECK && r_reg.armed && need != '0 && edge_seen
      && cnt < lo && is_rx(r_next.ctrl1) && !wr) |=> r_reg.checks == '0 && !r_reg.armed)
    else $error("short interval did not abort the check");
  a_check_high_fail:
    assert property ((r_reg.st == ST_CHECK && r_reg.armed && !edge_seen && cnt >= hi
      && need != '0) |=> r_reg.st != ST_RECV && r_reg.checks == '0)
    else $error("interval reaching the upper limit did not fail");
  a_recv_clock_on:
    assert property ((r_reg.st == ST_CHECK && enter_recv && is_rx(r_next.ctrl1))
      |=> r_reg.st == ST_RECV && r_reg.ctrl3[CLKON_BIT])
    else $error("receiving entered without host clock on");
  a_recv_irq:
    assert property ((enter_recv && !ts && !ps) |=> irq)
    else $error("no interrupt on receiving entry");
  a_transparent_out:
    assert property ((r_reg.st == ST_RECV && ts && !cs_active) |=>
      !serial_out_oe_n && serial_out_transparent == $past(demod_in))
    else $error("transparent output does not follow demodulator");
  a_count_bound:
    assert property (r_reg.count <= FULL)
    else $error("byte counter above buffer depth");
  a_bit_error_restart:
    assert property ((bit_err && !wr && is_rx(r_reg.ctrl1)) |=> r_reg.st == ST_SIGPROC && irq)
    else $error("bit error did not restart start-up");
  a_cfg_write_reset:
    assert property ((wr && addr == ADDR_CTRL5 && r_reg.st == ST_RECV) |=> r_reg.count == '0)
    else $error("configuration write did not clear the byte counter");
  a_pop_decrement:
    assert property ((rd && addr == ADDR_BUFFER && r_reg.count != '0 && !(wr && is_cfg(addr)))
      ##0 (r_reg.st != ST_RECV) |=> r_reg.count == $past(r_reg.count) - 1'b1)
    else $error("buffer read did not decrement the counter");
endmodule
`default_nettype wire

// ===== sim/tx_stream_model.sv
/*
  Far-side transmitter model: check tick source and demodulated stream.
  Assumes one clock; the bench queues half-bit levels with push_half.
*/
`timescale 1ns/10ps
`default_nettype none
module tx_stream_model (
  input wire logic clk,
  input wire logic rst,
  output logic tick,
  output logic demod_in,
  output logic busy
);
  logic lv_q[$];
  int n_q[$];
  int remain;
  logic div_reg;

  task automatic push_half(input logic lv, input int n);
    lv_q.push_back(lv);
    n_q.push_back(n);
  endtask

  // Manchester bit: rising centre edge gives 1, falling gives 0
  task automatic push_bit(input logic b, input int n);
    push_half(!b, n);
    push_half(b, n);
  endtask

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 1'b0;
      tick <= 1'b0;
      demod_in <= 1'b0;
      busy <= 1'b0;
      remain <= 0;
    end else begin
      div_reg <= !div_reg;
      tick <= div_reg;
      if (remain == 0 && lv_q.size() > 0) begin
        demod_in <= lv_q.pop_front();
        remain <= n_q.pop_front();
        busy <= 1'b1;
      end else if (tick && remain > 0) begin
        remain <= remain - 1;
        busy <= (remain > 1) || (lv_q.size() > 0);
      end else begin
        busy <= (remain > 0) || (lv_q.size() > 0);
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_rx_bitcheck_and_receive_buffer.sv
/*
  Self-checking bench for the receive bit-check and buffer block.
  Assumes the transmitter model makes tick and demod_in; random data
  comes from an xorshift generator seeded with 42.
*/
`timescale 1ns/10ps
`default_nettype none
module test_rx_bitcheck_and_receive_buffer;
  import rx_bitcheck_pkg::*;
  localparam int HALF = 19;
  localparam logic [4:0] RA [6] = '{ADDR_CTRL1, ADDR_CTRL3, ADDR_CTRL4,
    ADDR_CTRL5, ADDR_CTRL6, ADDR_CTRL7};
  localparam logic [7:0] RV [6] = '{CTRL1_RESET, CTRL3_RESET, CTRL4_RESET,
    CTRL5_RESET, CTRL6_RESET, CTRL7_RESET};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v;
  logic wr, rd, pll_lock, tick, demod_in, cs_active, wake, irq_clear, d;
  logic pll_enable, sigproc_enable, rx_active, irq, sot, oe_n, tx_busy;
  logic [31:0] seed = 32'h0000002a;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  rx_bitcheck_and_receive_buffer #(.BUF_DEPTH(16), .SIGPROC_TICKS(2))
  i_rx_bitcheck_and_receive_buffer (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pll_lock(pll_lock),
    .tick(tick), .demod_in(demod_in), .cs_active(cs_active), .wake(wake),
    .irq_clear(irq_clear), .pll_enable(pll_enable),
    .sigproc_enable(sigproc_enable), .rx_active(rx_active), .irq(irq),
    .serial_out_transparent(sot), .serial_out_oe_n(oe_n));

  tx_stream_model i_tx_stream_model (.clk(clk), .rst(rst), .tick(tick),
    .demod_in(demod_in), .busy(tx_busy));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] dat);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    dat = rdata;
  endtask

  task automatic pulse_clear();
    @(posedge clk);
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    #1;
    while (irq !== 1'b1 && i < 20000) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 20000) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wait_state(input logic [2:0] st);
    int i;
    logic [7:0] s;
    i = 0;
    rd_reg(ADDR_STATUS, s);
    while (s[7:5] !== st && i < 4000) begin
      rd_reg(ADDR_STATUS, s);
      i++;
    end
    if (i == 4000) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wait_tx();
    int i;
    i = 0;
    while (tx_busy !== 1'b0 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (i == 20000) begin
      n_errors++;
      end_of_test();
    end
  endtask

  // Zero preburst, then random bytes; four trailing bits never finish a byte
  task automatic send_frame(input int npre, input int nbytes);
    int i, k;
    logic [7:0] byt;
    for (i = 0; i < npre; i++) i_tx_stream_model.push_bit(1'b0, HALF);
    for (k = 0; k < nbytes; k++) begin
      seed = xorshift(seed);
      byt = seed[7:0];
      if (k == 0) byt[7] = 1'b1; // Start bit opposite to zero preburst
      for (i = 7; i >= 0; i--) i_tx_stream_model.push_bit(byt[i], HALF);
      exp_q.push_back(byt);
    end
    if (nbytes > 0) begin
      for (i = 0; i < 4; i++) i_tx_stream_model.push_bit(1'b0, HALF);
    end
  endtask

  initial begin
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pll_lock = 1'b0;
    cs_active = 1'b0;
    wake = 1'b0;
    irq_clear = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(RA[i], v);
      check(v, RV[i]);
    end
    wr_reg(5'h1f, 8'ha5);
    rd_reg(5'h1f, v);
    check(v, 8'h00);
    wr_reg(ADDR_CTRL5, 8'h4e); // Lower limit 14, three bits
    wr_reg(ADDR_CTRL6, 8'h18); // Upper limit 24
    wr_reg(ADDR_CTRL1, 8'h03); // Continuous receive, threshold one
    repeat (8) @(posedge clk);
    #1;
    check({6'h0, pll_enable, sigproc_enable}, 8'h02);
    @(posedge clk);
    pll_lock <= 1'b1;
    send_frame(16, 2);
    wait_irq();
    check({5'h0, pll_enable, sigproc_enable, rx_active}, 8'h07);
    rd_reg(ADDR_STATUS, v);
    check({5'h0, v[7:5]}, {5'h0, ST_RECV});
    rd_reg(ADDR_CTRL3, v);
    check({7'h0, v[CLKON_BIT]}, 8'h01);
    pulse_clear();
    wait_irq();
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h01);
    pulse_clear();
    wait_irq();
    check({7'h0, rx_active}, 8'h00);
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h02);
    while (exp_q.size() > 0) begin
      rd_reg(ADDR_BUFFER, v);
      check(v, exp_q.pop_front());
    end
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h00);
    pulse_clear();
    wr_reg(ADDR_CTRL1, 8'h0b); // Transparent continuous receive
    wait_tx();
    send_frame(24, 0);
    wait_state(ST_RECV);
    check({7'h0, irq}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      d = demod_in;
      @(posedge clk);
      #1;
      check({6'h0, oe_n, sot}, {7'h0, d});
    end
    @(posedge clk);
    cs_active <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({7'h0, oe_n}, 8'h01);
    wr_reg(ADDR_CTRL4, 8'h00);
    #1;
    check({5'h0, pll_enable, sigproc_enable, rx_active}, 8'h06);
    @(posedge clk);
    cs_active <= 1'b0;
    wait_tx();
    wr_reg(ADDR_CTRL1, 8'h02); // Polling receive
    for (int i = 0; i < 80; i++) i_tx_stream_model.push_half(i[0], 10);
    wait_state(ST_SLEEP);
    check({7'h0, pll_enable}, 8'h00);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    @(posedge clk);
    #1;
    check({7'h0, pll_enable}, 8'h01);
    wait_state(ST_SLEEP);
    wait_tx();
    wr_reg(ADDR_CTRL1, 8'h00);
    wr_reg(ADDR_CTRL1, 8'h73); // Buffered, pattern select, threshold twelve
    send_frame(16, 18);
    wait_irq();
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h0c);
    pulse_clear();
    wait_irq();
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h10);
    // Two oldest bytes were overwritten by the overflow
    void'(exp_q.pop_front());
    void'(exp_q.pop_front());
    while (exp_q.size() > 0) begin
      rd_reg(ADDR_BUFFER, v);
      check(v, exp_q.pop_front());
    end
    rd_reg(ADDR_STATUS, v);
    check({3'h0, v[4:0]}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
